// File: design/rcl_pkg.sv
// constants, field layout and decode helpers for the receiver control latch bank
package rcl_pkg;

  // select codes presented on io_select_line during a write cycle
  localparam logic [3:0] SEL_CNT_PRESET = 4'h5;
  localparam logic [3:0] SEL_FAULT_REAR = 4'h7;
  localparam logic [3:0] SEL_AGC_BOARD = 4'hA;
  localparam logic [3:0] SEL_BFO_DIGIT = 4'hB;
  localparam logic [3:0] SEL_FILTER = 4'hC;
  localparam logic [3:0] SEL_AGC_MODE = 4'hD;
  localparam logic [3:0] SEL_DAC = 4'hE;
  localparam logic [3:0] SEL_AUDIO_XPT = 4'hF;
  localparam logic [3:0] SEL_BOARD_FIRST = 4'hA;

  // select codes presented during a read cycle
  localparam logic [3:0] SEL_RD_METER = 4'h0;
  localparam logic [3:0] SEL_RD_UNLOCK = 4'h1;

  localparam int BOARD_STB_W = 6;
  localparam int BOARD_IDX_FILTER = 2;
  localparam int BOARD_IDX_AGC_MODE = 3;
  localparam int BOARD_IDX_DAC = 4;
  localparam int BOARD_IDX_AUDIO = 5;
  localparam int BOARD_IDX_AGC_BOARD = 0;

  // field positions
  localparam int BFO_EN_BIT = 4;
  localparam int SLOT1_BIT = 4;
  localparam int LIMITER_SRC_BIT = 5;
  localparam int AGC_DUMP_BIT = 6;
  localparam int DET_SEL_BIT = 0;
  localparam int AF_LEVEL_BIT = 1;
  localparam int METER_SRC_BIT = 2;
  localparam int XPT_W = 5;
  localparam int METER_ISB_BIT = 4;
  localparam int METER_AGC_BIT = 3;
  localparam logic [2:0] FAULT_DEC_OUT = 3'h5;
  localparam logic [2:0] SLOT_FIRST_BCD = 3'h2;

  // reset values and counter step
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;

  // one-hot decode of a 4-bit code into sixteen lines
  function automatic logic [15:0] rcl_onehot16(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h0000;
    r[code] = 1'b1;
    return r;
  endfunction

  // one-of-ten decode; codes ten to fifteen select nothing
  function automatic logic [9:0] rcl_one_of_ten(input logic [3:0] code);
    logic [15:0] r;
    r = rcl_onehot16(code);
    return r[9:0];
  endfunction

endpackage

// File: design/rcl_board_if.sv
// translated data bus and board strobes toward the signal-path control board
`timescale 1ns/1ps
`default_nettype none
interface rcl_board_if;
  logic [7:0] data;
  logic [rcl_pkg::BOARD_STB_W-1:0] stb;
  modport src (output data, output stb);
  modport dst (input data, input stb);
endinterface
`default_nettype wire

// File: design/rcl_signal_board.sv
// strobe-clocked latches of the signal-path control board and the optional agc board
`timescale 1ns/1ps
`default_nettype none
module rcl_signal_board (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset
  rcl_board_if.dst brd, // translated bus and strobes
  output logic [7:1] filter_slot, // filter slot select: slots 2..7 from the bcd code, slot 1 from bit 4, so slot 1 can be set alongside another
  output logic bfo_to_limiter, // limiter source: 1 = bfo, 0 = if
  output logic agc_dump, // agc dump line
  output logic [15:0] agc_mode, // two agc mode latches
  output logic detector_sel, // detector select switch
  output logic af_level, // audio filter level switch
  output logic meter_src, // audio meter source switch
  output logic [7:0] dac_code, // dac input word
  output logic [4:0] xpt_code, // crosspoint switch word
  output logic [15:0] agc_board_ctl // optional agc board latches
);
  typedef struct packed {
    logic [7:0] filter;
    logic [7:0] path;
    logic dump;
    logic [15:0] agc;
    logic [7:0] audio;
    logic [7:0] dac;
    logic [4:0] xpt;
    logic [15:0] agcb;
  } rcl_board_state_t;

  rcl_board_state_t st_reg, st_next;
  logic [9:0] bcd_lines;

  // --------------------------------------------------------------
  // latch capture
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg; // [RULE_21]
    if (brd.stb[rcl_pkg::BOARD_IDX_FILTER]) begin
      st_next.filter = brd.data; // [RULE_05]
      st_next.path = brd.data; // [RULE_07]
      st_next.dump = brd.data[rcl_pkg::AGC_DUMP_BIT]; // [RULE_07]
    end
    if (brd.stb[rcl_pkg::BOARD_IDX_AGC_MODE]) begin
      st_next.agc = {brd.data, brd.data}; // [RULE_08]
    end
    if (brd.stb[rcl_pkg::BOARD_IDX_AUDIO]) begin
      st_next.audio = brd.data; // [RULE_09]
      st_next.xpt = brd.data[rcl_pkg::XPT_W-1:0]; // [RULE_11]
    end
    if (brd.stb[rcl_pkg::BOARD_IDX_DAC]) begin
      st_next.dac = brd.data; // [RULE_10]
    end
    if (brd.stb[rcl_pkg::BOARD_IDX_AGC_BOARD]) begin
      st_next.agcb = {brd.data, brd.data}; // [RULE_12]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // only the low nibble is the bcd code; bit 4 bypasses the decoder
  assign bcd_lines = rcl_pkg::rcl_one_of_ten(st_reg.filter[3:0]); // [RULE_05]
  assign filter_slot = {bcd_lines[7:2], st_reg.filter[rcl_pkg::SLOT1_BIT]}; // [RULE_05] [RULE_06]
  assign bfo_to_limiter = st_reg.path[rcl_pkg::LIMITER_SRC_BIT]; // [RULE_07]
  assign agc_dump = st_reg.dump;
  assign agc_mode = st_reg.agc;
  assign detector_sel = st_reg.audio[rcl_pkg::DET_SEL_BIT]; // [RULE_09]
  assign af_level = st_reg.audio[rcl_pkg::AF_LEVEL_BIT];
  assign meter_src = st_reg.audio[rcl_pkg::METER_SRC_BIT];
  assign dac_code = st_reg.dac;
  assign xpt_code = st_reg.xpt;
  assign agc_board_ctl = st_reg.agcb;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_filter_one_hot: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
    brd.stb[rcl_pkg::BOARD_IDX_FILTER] && brd.data[3:0] >= 4'h2 && brd.data[3:0] <= 4'h7
    |=> $onehot(filter_slot[7:2]))
    else $error("filter slot select not one-hot");
  a_dac_load: assert property (@(posedge clk) disable iff (reset) // [RULE_10]
    brd.stb[rcl_pkg::BOARD_IDX_DAC] |=> dac_code == $past(brd.data))
    else $error("dac did not load bus word");
  a_dac_hold: assert property (@(posedge clk) disable iff (reset) // [RULE_21]
    !brd.stb[rcl_pkg::BOARD_IDX_DAC] |=> $stable(dac_code))
    else $error("dac changed without its strobe");
  a_agc_board_load: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
    brd.stb[rcl_pkg::BOARD_IDX_AGC_BOARD] |=> agc_board_ctl[7:0] == $past(brd.data))
    else $error("agc board latch missed strobe");
endmodule
`default_nettype wire

// File: design/rcl_latch_bank.sv
// receiver control latch bank: bus latch, strobe decode, bfo digits, unlock and meter inputs
//
// How it works
// RULE_01 - shared counter bits address four bfo latches
// RULE_02 - bfo digit latches load on strobe 11
// RULE_03 - first bfo latch bit 4 enables synthesizer
// RULE_04 - bus and strobes 10-15 forwarded to board
// RULE_05 - strobe 12 bcd code picks slot 2-7
// RULE_06 - filter latch bit 4 drives slot 1
// RULE_07 - strobe 12 latch sets limiter source, dump
// RULE_08 - strobe 13 loads two agc mode latches
// RULE_09 - strobe 15 latch sets detector, audio switches
// RULE_10 - dac loads eight bits on strobe 14
// RULE_11 - crosspoint takes five bits on strobe 15
// RULE_12 - agc board latches load on strobe 10
// RULE_13 - unlock input sets sticky unlock flag, led
// RULE_14 - unlock read clocks flags back low
// RULE_15 - unlock flags readable on the data bus
// RULE_16 - counter decode 5 drives fault outputs, inverted
// RULE_17 - meter buffer returns comparators, isb fitted
// RULE_18 - processor reads meter repeatedly for bar graph
// RULE_19 - processor makes strobes from select code
// RULE_20 - write data captured in bus latch
// RULE_21 - unselected latches keep their contents
`timescale 1ns/1ps
`default_nettype none
module rcl_latch_bank (
  input wire logic clk, // 50 MHz system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic [3:0] io_select_line, // select code for this cycle
  input wire logic [7:0] wdata, // write data
  input wire logic wr_strobe, // one-cycle write strobe
  input wire logic rd_strobe, // one-cycle read strobe
  output logic [7:0] rdata, // read data, cycle after rd_strobe
  input wire logic [2:0] lock_lost, // loop monitors, high when out of lock
  input wire logic [2:0] meter_cmp, // meter comparator states
  input wire logic isb_fitted, // isb fitted indication
  input wire logic agc_board_fitted, // optional agc board present
  output logic [31:0] bfo_digits, // four bfo digit latches
  output logic bfo_synth_en, // bfo synthesizer enable
  output logic [2:0] loop_unlock_flag, // sticky unlock flags
  output logic [2:0] unlock_led_n, // unlock indicators, active low
  output logic fault_rear_n, // rear panel fault level, active low
  output logic fault_front_n, // front panel fault indicator, active low
  output logic [7:0] board_data, // bus toward the signal board
  output logic [5:0] board_strobe_group, // strobes 10..15 toward the board
  output logic [7:1] filter_slot, // filter slot select
  output logic bfo_to_limiter, // limiter source select
  output logic agc_dump, // agc dump line
  output logic [15:0] agc_mode, // agc mode latches
  output logic detector_sel, // detector select
  output logic af_level, // audio filter level
  output logic meter_src, // audio meter source
  output logic [7:0] dac_code, // dac word
  output logic [4:0] xpt_code, // crosspoint word
  output logic [15:0] agc_board_ctl // optional agc board controls
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bus_latch;
    logic [5:0] board_stb;
    logic [3:0] cnt;
    logic [3:0][7:0] bfo;
    logic [2:0] unlock;
    logic rear_n;
    logic front_n;
    logic [7:0] rdata;
  } rcl_bank_state_t;

  rcl_bank_state_t st_reg, st_next;
  logic [15:0] wr_sel;
  logic [15:0] rd_sel;
  logic [7:0] fault_dec;
  logic cnt_clock;
  logic [7:0] meter_word;
  logic [7:0] unlock_word;

  // --------------------------------------------------------------
  // strobe decode
  // --------------------------------------------------------------
  // the processor's select code is decoded here; strobes only exist
  // during the one cycle in which the matching strobe is high
  always_comb begin
    wr_sel = 16'h0000;
    rd_sel = 16'h0000;
    if (wr_strobe) begin
      wr_sel = rcl_pkg::rcl_onehot16(io_select_line); // [RULE_19]
    end
    if (rd_strobe) begin
      rd_sel = rcl_pkg::rcl_onehot16(io_select_line);
    end
  end

  // strobes 7, 11 and 15 all step the shared counter
  assign cnt_clock = wr_sel[rcl_pkg::SEL_FAULT_REAR] | wr_sel[rcl_pkg::SEL_BFO_DIGIT]
    | wr_sel[rcl_pkg::SEL_AUDIO_XPT];

  // counter bits 1..3 feed both the digit latches and the fault decoders
  assign fault_dec = {8'h00} | 8'(rcl_pkg::rcl_onehot16({1'b0, st_reg.cnt[3:1]})); // [RULE_16]

  // --------------------------------------------------------------
  // input buffers
  // --------------------------------------------------------------
  // agc board fitted pulls its pulled-up input low; absence reads as one
  always_comb begin
    meter_word = 8'h00;
    meter_word[2:0] = meter_cmp; // [RULE_17]
    meter_word[rcl_pkg::METER_AGC_BIT] = ~agc_board_fitted;
    meter_word[rcl_pkg::METER_ISB_BIT] = isb_fitted; // [RULE_17]
    unlock_word = {5'h00, st_reg.unlock}; // [RULE_15]
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg; // [RULE_21]
    st_next.board_stb = 6'h00;

    // write data lands in the bus latch and is forwarded with its strobe
    if (wr_strobe) begin
      st_next.bus_latch = wdata; // [RULE_20]
    end
    st_next.board_stb = wr_sel[15:10]; // [RULE_04]

    // shared counter: preset by its own strobe, else stepped
    if (wr_sel[rcl_pkg::SEL_CNT_PRESET]) begin
      st_next.cnt = wdata[3:0];
    end else if (cnt_clock) begin
      st_next.cnt = st_reg.cnt + rcl_pkg::CNT_STEP;
    end

    // each digit latch stores one data bit at the counter's address
    if (wr_sel[rcl_pkg::SEL_BFO_DIGIT]) begin
      for (int k = 0; k < 4; k++) begin
        st_next.bfo[k][st_reg.cnt[3:1]] = wdata[k]; // [RULE_01] [RULE_02]
      end
    end

    // fault levels follow decoder output 5, sampled on their strobes
    if (wr_sel[rcl_pkg::SEL_FAULT_REAR]) begin
      st_next.rear_n = ~(fault_dec[rcl_pkg::FAULT_DEC_OUT] & wdata[0]); // [RULE_16]
    end
    if (wr_sel[rcl_pkg::SEL_BFO_DIGIT]) begin
      st_next.front_n = ~(fault_dec[rcl_pkg::FAULT_DEC_OUT] & wdata[0]); // [RULE_16]
    end

    // unlock flags: a read of the flags clocks a low in, but a monitor
    // still out of lock holds its flag set, so the set always wins
    if (rd_sel[rcl_pkg::SEL_RD_UNLOCK]) begin
      st_next.unlock = 3'h0; // [RULE_14]
    end
    st_next.unlock = st_next.unlock | lock_lost; // [RULE_13]

    // read data stand in the cycle after the read strobe only
    st_next.rdata = 8'h00;
    if (rd_sel[rcl_pkg::SEL_RD_METER]) begin
      st_next.rdata = meter_word; // [RULE_17]
    end else if (rd_sel[rcl_pkg::SEL_RD_UNLOCK]) begin
      st_next.rdata = unlock_word; // [RULE_15]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.rear_n <= 1'b1;
      st_reg.front_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign rdata = st_reg.rdata;
  assign bfo_digits = st_reg.bfo;
  assign bfo_synth_en = st_reg.bfo[0][rcl_pkg::BFO_EN_BIT]; // [RULE_03]
  assign loop_unlock_flag = st_reg.unlock;
  assign unlock_led_n = ~st_reg.unlock; // [RULE_13]
  assign fault_rear_n = st_reg.rear_n;
  assign fault_front_n = st_reg.front_n;
  assign board_data = st_reg.bus_latch;
  assign board_strobe_group = st_reg.board_stb;

  // --------------------------------------------------------------
  // signal-path board
  // --------------------------------------------------------------
  rcl_board_if brd_link ();

  assign brd_link.data = st_reg.bus_latch; // [RULE_04]
  assign brd_link.stb = st_reg.board_stb;

  rcl_signal_board u_board (
    .clk(clk),
    .reset(reset),
    .brd(brd_link.dst),
    .filter_slot(filter_slot),
    .bfo_to_limiter(bfo_to_limiter),
    .agc_dump(agc_dump),
    .agc_mode(agc_mode),
    .detector_sel(detector_sel),
    .af_level(af_level),
    .meter_src(meter_src),
    .dac_code(dac_code),
    .xpt_code(xpt_code),
    .agc_board_ctl(agc_board_ctl)
  );

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence s_bfo_write_en;
    wr_strobe && io_select_line == rcl_pkg::SEL_BFO_DIGIT && st_reg.cnt[3:1] == 3'h4;
  endsequence

  a_bfo_enable_bit: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
    s_bfo_write_en |=> bfo_synth_en == $past(wdata[0]))
    else $error("bfo enable does not follow latch 0 bit 4");

  a_bfo_digit_hold: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
    !(wr_strobe && io_select_line == rcl_pkg::SEL_BFO_DIGIT) |=> $stable(bfo_digits))
    else $error("bfo digits changed without strobe 11");

  a_bfo_addr_step: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
    wr_strobe && io_select_line == rcl_pkg::SEL_BFO_DIGIT
    |=> bfo_digits[$past(st_reg.cnt[3:1])] == $past(wdata[0]))
    else $error("bfo bit stored at wrong counter address");

  sequence s_board_write;
    wr_strobe && io_select_line == rcl_pkg::SEL_FILTER;
  endsequence

  a_board_forward: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
    s_board_write |=> board_strobe_group == 6'h04 && board_data == $past(wdata)
    ##1 board_strobe_group == 6'h00)
    else $error("strobe 12 not forwarded for exactly one cycle");

  a_unlock_set: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
    lock_lost[0] |=> loop_unlock_flag[0] && !unlock_led_n[0])
    else $error("unlock flag not set by monitor");

  a_unlock_clear: assert property (@(posedge clk) disable iff (reset) // [RULE_14]
    rd_strobe && io_select_line == rcl_pkg::SEL_RD_UNLOCK && lock_lost == 3'h0
    |=> loop_unlock_flag == 3'h0)
    else $error("unlock read did not clear flags");

  a_unlock_read: assert property (@(posedge clk) disable iff (reset) // [RULE_15]
    rd_strobe && io_select_line == rcl_pkg::SEL_RD_UNLOCK
    |=> rdata[2:0] == $past(loop_unlock_flag) ##1 rdata == 8'h00 || $past(rd_strobe))
    else $error("unlock flags not returned on read");

  a_meter_read: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
    rd_strobe && io_select_line == rcl_pkg::SEL_RD_METER
    |=> rdata[2:0] == $past(meter_cmp) && rdata[4] == $past(isb_fitted))
    else $error("meter buffer word wrong");

  a_fault_front: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
    wr_strobe && io_select_line == rcl_pkg::SEL_BFO_DIGIT && st_reg.cnt[3:1] == 3'h5
    |=> fault_front_n == !$past(wdata[0]))
    else $error("front fault level wrong");

  a_bus_latch: assert property (@(posedge clk) disable iff (reset) // [RULE_20]
    wr_strobe |=> board_data == $past(wdata) ##1 ($past(wr_strobe) || $stable(board_data)))
    else $error("bus latch lost write data");

endmodule
`default_nettype wire

// File: tb/rcl_cpu_model.sv
// processor-side bus master model for the receiver control latch bank
`timescale 1ns/1ps
`default_nettype none
module rcl_cpu_model (
  input wire logic clk, // system clock
  output logic [3:0] io_select_line, // select code
  output logic [7:0] wdata, // write data
  output logic wr_strobe, // write strobe
  output logic rd_strobe, // read strobe
  input wire logic [7:0] rdata // read data
);
  // --------------------------------
  // bus cycles
  // --------------------------------
  initial begin
    io_select_line = 4'h0;
    wdata = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end

  // data goes stale once the strobe drops, so a late capture shows up
  task automatic wr(input logic [3:0] code, input logic [7:0] d);
    @(posedge clk);
    io_select_line <= code;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] code, output logic [7:0] d);
    @(posedge clk);
    io_select_line <= code;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask

  // comparator on meter bit 0 is polled once per trial bit
  task automatic sar(output logic [7:0] code);
    logic [7:0] m;
    code = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      wr(rcl_pkg::SEL_DAC, code | (8'h01 << b));
      repeat (2) @(posedge clk);
      rd(rcl_pkg::SEL_RD_METER, m);
      if (m[0]) begin
        code = code | (8'h01 << b);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: tb/rcl_latch_bank_tb.sv
// self-checking bench for the receiver control latch bank
`timescale 1ns/1ps
`default_nettype none
module rcl_latch_bank_tb;
  localparam logic [7:0] LEVEL = 8'h9C;
  localparam logic [56:0] LATCH_EXP = {16'h3535, 16'h6868, 8'h79, 5'h0A, 3'b010, 7'h41, 2'b01};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] lock_lost = 3'h0;
  logic [2:0] meter_cmp = 3'h0;
  logic [2:0] cmp_set = 3'h0;
  logic isb_fitted = 1'b0;
  logic agc_board_fitted = 1'b0;
  logic sar_on = 1'b0;
  logic [3:0] io_select_line;
  logic [7:0] wdata, rdata, board_data, dac_code, got;
  logic wr_strobe, rd_strobe, bfo_synth_en, fault_rear_n, fault_front_n;
  logic bfo_to_limiter, agc_dump, detector_sel, af_level, meter_src;
  logic [31:0] bfo_digits;
  logic [2:0] loop_unlock_flag, unlock_led_n;
  logic [5:0] board_strobe_group;
  logic [7:1] filter_slot;
  logic [15:0] agc_mode, agc_board_ctl;
  logic [4:0] xpt_code;
  int err_total = 0;
  int n_tests = 0;

  // --------------------------------
  // harness
  // --------------------------------
  rcl_latch_bank u_rcl_latch_bank (
    .clk(clk), .reset(reset), .io_select_line(io_select_line), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .lock_lost(lock_lost),
    .meter_cmp(meter_cmp), .isb_fitted(isb_fitted), .agc_board_fitted(agc_board_fitted),
    .bfo_digits(bfo_digits), .bfo_synth_en(bfo_synth_en),
    .loop_unlock_flag(loop_unlock_flag), .unlock_led_n(unlock_led_n),
    .fault_rear_n(fault_rear_n), .fault_front_n(fault_front_n), .board_data(board_data),
    .board_strobe_group(board_strobe_group), .filter_slot(filter_slot),
    .bfo_to_limiter(bfo_to_limiter), .agc_dump(agc_dump), .agc_mode(agc_mode),
    .detector_sel(detector_sel), .af_level(af_level), .meter_src(meter_src),
    .dac_code(dac_code), .xpt_code(xpt_code), .agc_board_ctl(agc_board_ctl)
  );
  rcl_cpu_model u_rcl_cpu_model (
    .clk(clk), .io_select_line(io_select_line), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // comparator trips while the dac word is at or below the level
  always @(posedge clk) begin
    meter_cmp <= sar_on ? {2'b00, (dac_code <= LEVEL)} : cmp_set;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic summarize;
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] c, input logic [7:0] d);
    u_rcl_cpu_model.wr(c, d);
  endtask

  task automatic rd(input logic [3:0] c, output logic [7:0] d);
    u_rcl_cpu_model.rd(c, d);
  endtask

  function automatic logic [56:0] latch_view();
    return {agc_board_ctl, agc_mode, dac_code, xpt_code, detector_sel, af_level, meter_src,
      filter_slot, bfo_to_limiter, agc_dump};
  endfunction

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({rdata, loop_unlock_flag, unlock_led_n}, {8'h00, 3'h0, 3'h7});
    chk({fault_rear_n, fault_front_n}, 2'b11);
    chk({bfo_digits, dac_code, agc_mode}, 64'h0);
  endtask

  task automatic t_filter;
    logic [7:0] d[3] = '{8'h72, 8'h07, 8'h19};
    logic [8:0] e[3] = '{9'h00F, 9'h100, 9'h004};
    for (int i = 0; i < 3; i++) begin
      wr(rcl_pkg::SEL_FILTER, d[i]);
      #1;
      chk({board_data, board_strobe_group}, {d[i], 6'h04});
      @(posedge clk);
      #1;
      chk(board_strobe_group, 6'h00);
      chk({filter_slot, bfo_to_limiter, agc_dump}, e[i]);
    end
  endtask

  task automatic t_strobes;
    for (int i = 0; i < 6; i++) begin
      wr(4'(rcl_pkg::SEL_BOARD_FIRST + i), 8'(8'h35 + 8'h11 * i));
      #1;
      chk(board_strobe_group, 64'h1 << i);
    end
    @(posedge clk);
    #1;
    chk(latch_view(), LATCH_EXP);
    wr(4'h3, 8'hFF);
    #1;
    chk({board_data, board_strobe_group}, {8'hFF, 6'h00});
    @(posedge clk);
    #1;
    chk(latch_view(), LATCH_EXP);
  endtask

  task automatic t_bfo;
    logic [31:0] exp;
    logic [7:0] d;
    exp = 32'h0;
    wr(rcl_pkg::SEL_CNT_PRESET, 8'h00);
    for (int j = 0; j < 16; j++) begin
      d = 8'(j * 7);
      wr(rcl_pkg::SEL_BFO_DIGIT, d);
      for (int k = 0; k < 4; k++) exp[8 * k + j / 2] = d[k];
      #1;
      chk(fault_front_n, !(j / 2 == 5 && d[0]));
    end
    chk({bfo_synth_en, bfo_digits}, {exp[4], exp});
  endtask

  task automatic t_fault;
    wr(rcl_pkg::SEL_CNT_PRESET, 8'h0A);
    for (int i = 0; i < 3; i++) begin
      wr(rcl_pkg::SEL_FAULT_REAR, {7'h00, i != 1});
      #1;
      chk(fault_rear_n, i != 0);
    end
  endtask

  task automatic t_unlock;
    @(posedge clk);
    lock_lost <= 3'b010;
    @(posedge clk);
    lock_lost <= 3'b000;
    @(posedge clk);
    #1;
    chk({loop_unlock_flag, unlock_led_n}, 6'b010_101);
    rd(rcl_pkg::SEL_RD_UNLOCK, got);
    chk({got, loop_unlock_flag}, 11'h010);
    @(posedge clk);
    lock_lost <= 3'b001;
    rd(rcl_pkg::SEL_RD_UNLOCK, got);
    chk({got, loop_unlock_flag}, 11'h009);
    @(posedge clk);
    lock_lost <= 3'b000;
  endtask

  task automatic t_meter;
    logic [7:0] code;
    @(posedge clk);
    cmp_set <= 3'b101;
    isb_fitted <= 1'b1;
    rd(rcl_pkg::SEL_RD_METER, got);
    chk(got, 8'h1D);
    @(posedge clk);
    cmp_set <= 3'b010;
    isb_fitted <= 1'b0;
    agc_board_fitted <= 1'b1;
    rd(rcl_pkg::SEL_RD_METER, got);
    chk(got, 8'h02);
    rd(4'h2, got);
    chk(got, 8'h00);
    @(posedge clk);
    sar_on <= 1'b1;
    u_rcl_cpu_model.sar(code);
    chk(code, LEVEL);
  endtask

  initial begin
    t_reset();
    t_filter();
    t_strobes();
    t_bfo();
    t_fault();
    t_unlock();
    t_meter();
    t_reset();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
